/* dpi_tracker.sv */
/*
 * Device-side model of the power-up sequence and burst access decode.
 * Assumes the controller drives commands synchronous to I_SYS_CLK and
 * that software reads status and restarts the sequence tracker over APB.
 */
`timescale 1ns/1ns
module dpi_tracker
    import dpi_pkg::*;
(
    // Clock and reset.
    input  wire logic              I_SYS_CLK,
    input  wire logic              I_RST,
    // Command and address pins.
    input  wire logic              I_CKE,
    input  wire logic              I_CS_N,
    input  wire logic              I_RAS_N,
    input  wire logic              I_CAS_N,
    input  wire logic              I_WE_N,
    input  wire logic [BANK_W-1:0] I_BA,
    input  wire logic [ADDR_W-1:0] I_A,
    // APB slave.
    input  wire logic              I_PSEL,
    input  wire logic              I_PENABLE,
    input  wire logic              I_PWRITE,
    input  wire logic [11:0]       I_PADDR,
    input  wire logic [31:0]       I_PWDATA,
    output logic      [31:0]       O_PRDATA,
    output logic                   O_PREADY,
    output logic                   O_PSLVERR,
    // Device status.
    output logic                   O_READY,
    output logic                   O_DIFF_DQS,
    output logic                   O_BURST_VALID,
    output logic      [COL_W-1:0]  O_BURST_COL
);

    // ****************************************************************
    // Command decode
    // ****************************************************************
    dpi_cmd_t   c;
    dpi_state_t state_r;
    dpi_state_t state_nxt;
    logic       is_mrs, is_ref, is_pre, is_act, is_rd, is_wr, pall;
    logic [ADDR_W-1:0] mr_r, emr1_r;
    logic [1:0]  emr23_r;
    logic [1:0]  ref_cnt_r;
    logic [7:0]  lock_cnt_r;
    logic [3:0]  open_r;
    logic [ADDR_W-1:0] row_r [4];
    logic [31:0] ctrl_r;
    logic [2:0]  beat_r;
    logic [COL_W-1:0] start_r;
    logic        ap_r;
    logic        err_r;

    // Gather the pins and decode the command.
    assign c      = '{I_CKE, {I_CS_N, I_RAS_N, I_CAS_N, I_WE_N}, I_BA, I_A};
    assign is_mrs = c.cke && c.cmd == CMD_MRS;
    assign is_ref = c.cke && c.cmd == CMD_REF;
    assign is_pre = c.cke && c.cmd == CMD_PRE;
    assign is_act = c.cke && c.cmd == CMD_ACT;
    assign is_rd  = c.cke && c.cmd == CMD_RD;
    assign is_wr  = c.cke && c.cmd == CMD_WR;
    assign pall   = is_pre && c.a[A_AP];

    // ****************************************************************
    // Initialization sequencer
    // ****************************************************************
    // Walk the ordered steps; a wrong setting in an awaited command lands in the bad state, other commands are ignored.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_WAIT_CKE:   if (c.cke) state_nxt = ST_WAIT_PALL1;
            ST_WAIT_PALL1: if (pall) state_nxt = ST_WAIT_EMR1;
            ST_WAIT_EMR1:
                // Registers two and three may still follow the DLL reset.
                if (is_mrs && c.ba == BA_EMR1) begin
                    state_nxt = !c.a[A_DLLDIS] ? ST_WAIT_MRDLL
                                               : ST_BAD;
                end
            ST_WAIT_MRDLL:
                if (is_mrs && c.ba == BA_MR) begin
                    state_nxt = c.a[A_DLLRST] ? ST_WAIT_PALL2
                                              : ST_BAD;
                end
            ST_WAIT_PALL2:
                if (pall) begin
                    state_nxt = (emr23_r == 2'b11) ? ST_WAIT_REF
                                                   : ST_BAD;
                end
            ST_WAIT_REF:
                if (is_mrs && c.ba == BA_MR) begin
                    state_nxt = (ref_cnt_r >= MIN_REFRESH &&
                                 !c.a[A_DLLRST]) ? ST_WAIT_OCD
                                                 : ST_BAD;
                end
            ST_WAIT_OCD:
                if (is_mrs && c.ba == BA_EMR1 &&
                    c.a[A_OCD_LO+:3] == OCD_DFLT) begin
                    state_nxt = (lock_cnt_r == '0) ? ST_WAIT_OCDX
                                                   : ST_BAD;
                end
            ST_WAIT_OCDX:
                if (is_mrs && c.ba == BA_EMR1 &&
                    c.a[A_OCD_LO+:3] == OCD_EXIT) begin
                    state_nxt = ST_READY;
                end
            ST_READY:      state_nxt = ST_READY;
            default:       state_nxt = ST_BAD;
        endcase
        // Clock enable must not drop before the sequence completes.
        if (state_r != ST_WAIT_CKE && state_r != ST_READY && !c.cke) begin
            state_nxt = ST_BAD;
        end
    end

    // State register.
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            state_r <= ST_WAIT_CKE;
        end else if (ctrl_r[0]) begin
            state_r <= ST_WAIT_CKE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Mode register contents and extended register two/three marks.
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            mr_r    <= '0;
            emr1_r  <= '0;
            emr23_r <= '0;
        end else if (ctrl_r[0]) begin
            // A restart forgets earlier marks so each run proves them.
            emr23_r <= '0;
        end else if (is_mrs) begin
            case (c.ba)
                BA_MR:   mr_r <= c.a;
                BA_EMR1: emr1_r <= c.a;
                BA_EMR2: emr23_r[0] <= 1'b1;
                BA_EMR3: emr23_r[1] <= 1'b1;
                default: emr1_r <= emr1_r;
            endcase
        end
    end

    // Refresh count after the second precharge-all.
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            ref_cnt_r <= '0;
        end else if (state_r != ST_WAIT_REF) begin
            ref_cnt_r <= '0;
        end else if (is_ref && ref_cnt_r != MIN_REFRESH) begin
            ref_cnt_r <= ref_cnt_r + 2'h1;
        end
    end

    // DLL lock timer started by the DLL reset write.
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            lock_cnt_r <= DLL_LOCK_CNT;
        end else if (is_mrs && c.ba == BA_MR && c.a[A_DLLRST]) begin
            lock_cnt_r <= DLL_LOCK_CNT - 8'h1;
        end else if (lock_cnt_r != '0) begin
            lock_cnt_r <= lock_cnt_r - 8'h1;
        end
    end

    // ****************************************************************
    // Bank and burst tracking
    // ****************************************************************
    // Per-bank open row, set by activate and cleared by precharge.
    for (genvar b = 0; b < 4; b++) begin : g_bank
        always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
            if (I_RST) begin
                open_r[b] <= 1'b0;
                row_r[b]  <= '0;
            end else if (is_act && c.ba[1:0] == 2'(b)) begin
                open_r[b] <= 1'b1;
                row_r[b]  <= c.a;
            end else if (is_pre && (c.a[A_AP] ||
                                    c.ba[1:0] == 2'(b))) begin
                open_r[b] <= 1'b0;
            end else if ((is_rd || is_wr) && c.a[A_AP] &&
                         c.ba[1:0] == 2'(b)) begin
                open_r[b] <= 1'b0;
            end
        end
    end

    // Burst engine: column walks in sequential or interleaved order.
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            beat_r        <= '0;
            start_r       <= '0;
            ap_r          <= 1'b0;
            err_r         <= 1'b0;
            O_BURST_VALID <= 1'b0;
            O_BURST_COL   <= '0;
        end else if ((is_rd || is_wr) && state_r == ST_READY) begin
            if (!open_r[c.ba[1:0]]) begin
                err_r <= 1'b1;
            end
            start_r       <= c.a[COL_W-1:0];
            ap_r          <= c.a[A_AP];
            beat_r        <= 3'h1;
            O_BURST_VALID <= 1'b1;
            O_BURST_COL   <= c.a[COL_W-1:0];
        end else if (O_BURST_VALID) begin
            // The beat count wraps after eight, so the end is masked.
            if ((beat_r & ((mr_r[2:0] == BL_FOUR) ? BL_LEN4 : BL_LEN8))
                    == '0) begin
                O_BURST_VALID <= 1'b0;
            end else begin
                beat_r <= beat_r + 3'h1;
                O_BURST_COL <= mr_r[A_BT]
                    ? (start_r ^ COL_W'(beat_r))
                    : {start_r[COL_W-1:3],
                       (mr_r[2:0] == BL_FOUR)
                         ? {start_r[2], start_r[1:0] + beat_r[1:0]}
                         : start_r[2:0] + beat_r};
            end
        end
    end

    // Status outputs.
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_READY    <= 1'b0;
            O_DIFF_DQS <= 1'b0;
        end else begin
            O_READY    <= state_r == ST_READY;
            O_DIFF_DQS <= !emr1_r[A_SEDQS];
        end
    end

    // ****************************************************************
    // APB slave
    // ****************************************************************
    // Control register: bit 0 restarts the sequence tracker.
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            ctrl_r <= CTRL_RST;
        end else if (I_PSEL && I_PENABLE && I_PWRITE &&
                     I_PADDR == REG_CTRL) begin
            ctrl_r <= I_PWDATA;
        end else begin
            ctrl_r[0] <= 1'b0;
        end
    end

    // Zero-wait answers; unmapped addresses give an error.
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_PRDATA  <= '0;
            O_PREADY  <= 1'b0;
            O_PSLVERR <= 1'b0;
        end else begin
            O_PREADY  <= I_PSEL && !I_PENABLE;
            O_PSLVERR <= 1'b0;
            O_PRDATA  <= '0;
            if (I_PSEL && !I_PENABLE) begin
                case (I_PADDR)
                    REG_STATUS: O_PRDATA <= {20'h0_0000, err_r,
                        state_r == ST_BAD, open_r, 4'(state_r),
                        !emr1_r[A_SEDQS], state_r == ST_READY};
                    REG_CTRL:   O_PRDATA <= ctrl_r;
                    REG_MODE:   O_PRDATA <= {16'h0000, mr_r};
                    REG_EMR1:   O_PRDATA <= {16'h0000, emr1_r};
                    REG_ACCESS: O_PRDATA <= {19'h0_0000, ap_r,
                        2'h0, start_r};
                    default:    O_PSLVERR <= 1'b1;
                endcase
            end
        end
    end

endmodule : dpi_tracker

/* dpi_pkg.sv */
/*
 * Shared constants and types for the memory device power-up tracker.
 * Assumes a single 100 MHz system clock and an APB register port.
 */
package dpi_pkg;

    // ****************************************************************
    // Command and address widths
    // ****************************************************************
    localparam int ADDR_W = 16;
    localparam int BANK_W = 3;
    localparam int COL_W  = 10;

    // Command codes, {cs_n, ras_n, cas_n, we_n}.
    localparam logic [3:0] CMD_MRS = 4'h0;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_WR  = 4'h4;
    localparam logic [3:0] CMD_RD  = 4'h5;

    // Address bit positions.
    localparam int A_AP     = 10;
    localparam int A_DLLRST = 8;
    localparam int A_DLLDIS = 0;
    localparam int A_SEDQS  = 10;
    localparam int A_BT     = 3;
    localparam int A_OCD_LO = 7;

    // Bank codes that select the mode registers.
    localparam logic [2:0] BA_MR   = 3'h0;
    localparam logic [2:0] BA_EMR1 = 3'h1;
    localparam logic [2:0] BA_EMR2 = 3'h2;
    localparam logic [2:0] BA_EMR3 = 3'h3;

    localparam logic [2:0] BL_FOUR  = 3'h2;
    localparam logic [2:0] OCD_DFLT = 3'h7;
    localparam logic [2:0] OCD_EXIT = 3'h0;
    localparam logic [2:0] BL_LEN4  = 3'h3;
    localparam logic [2:0] BL_LEN8  = 3'h7;

    // Calibration may begin this many clocks after the DLL reset.
    localparam int         DLL_LOCK_CLKS = 200;
    localparam logic [7:0] DLL_LOCK_CNT  = 8'(DLL_LOCK_CLKS);
    localparam logic [1:0] MIN_REFRESH   = 2'h2;

    // ****************************************************************
    // APB register map
    // ****************************************************************
    localparam logic [11:0] REG_STATUS = 12'h000;
    localparam logic [11:0] REG_CTRL   = 12'h004;
    localparam logic [11:0] REG_MODE   = 12'h008;
    localparam logic [11:0] REG_EMR1   = 12'h00C;
    localparam logic [11:0] REG_ACCESS = 12'h010;
    localparam logic [31:0] CTRL_RST   = 32'h0000_0000;

    // One command as seen on the command and address pins.
    typedef struct packed {
        logic              cke;
        logic [3:0]        cmd;
        logic [BANK_W-1:0] ba;
        logic [ADDR_W-1:0] a;
    } dpi_cmd_t;

    typedef enum {
        ST_WAIT_CKE, ST_WAIT_PALL1, ST_WAIT_EMR1, ST_WAIT_MRDLL,
        ST_WAIT_PALL2, ST_WAIT_REF, ST_WAIT_MROP, ST_WAIT_OCD,
        ST_WAIT_OCDX, ST_READY, ST_BAD
    } dpi_state_t;

endpackage : dpi_pkg

/* dpi_tracker_sva.sv */
/*
 * Checker for the power-up tracker: burst framing, strobe mode, ready.
 * Assumes it is bound to the tracker and sees only its ports.
 */
`timescale 1ns/1ns
module dpi_tracker_sva
    import dpi_pkg::*;
(
    // Clock and reset.
    input  wire logic              I_SYS_CLK,
    input  wire logic              I_RST,
    // Command pins.
    input  wire logic              I_CKE,
    input  wire logic              I_CS_N,
    input  wire logic              I_RAS_N,
    input  wire logic              I_CAS_N,
    input  wire logic              I_WE_N,
    input  wire logic [BANK_W-1:0] I_BA,
    input  wire logic [ADDR_W-1:0] I_A,
    // APB and status.
    input  wire logic              I_PSEL,
    input  wire logic              I_PENABLE,
    input  wire logic              O_PREADY,
    input  wire logic              O_READY,
    input  wire logic              O_DIFF_DQS,
    input  wire logic              O_BURST_VALID,
    input  wire logic [COL_W-1:0]  O_BURST_COL
);
    // ****************************************************************
    // Command decode and assertions
    // ****************************************************************
    logic [3:0] cmd;
    logic       mrs;
    logic       acc;
    logic       exit1;
    logic       bl4_r;
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RST);
    // Decode the command pins the way the device samples them.
    assign cmd   = {I_CS_N, I_RAS_N, I_CAS_N, I_WE_N};
    assign mrs   = I_CKE && (cmd == CMD_MRS);
    assign acc   = I_CKE && O_READY && (cmd == CMD_RD || cmd == CMD_WR);
    assign exit1 = mrs && I_BA == BA_EMR1 && I_A[9:7] == OCD_EXIT;
    // Track the programmed burst length from mode register writes.
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            bl4_r <= 1'b0;
        end else if (mrs && I_BA == BA_MR) begin
            bl4_r <= (I_A[2:0] == BL_FOUR);
        end
    end
    AST_BURST_FOUR: assert property (acc && bl4_r |=>
        O_BURST_VALID [*4] ##1 !O_BURST_VALID) else $error("burst not 4");
    AST_BURST_EIGHT: assert property (acc && !bl4_r |=>
        O_BURST_VALID [*8] ##1 !O_BURST_VALID) else $error("burst not 8");
    AST_FIRST_COL: assert property (acc |=>
        O_BURST_COL == $past(I_A[COL_W-1:0])) else $error("start column");
    AST_STROBE_MODE: assert property (mrs && I_BA == BA_EMR1 |=> ##1
        O_DIFF_DQS == !$past(I_A[A_SEDQS], 2)) else $error("strobe mode");
    AST_READY_AFTER_EXIT: assert property ($rose(O_READY) |->
        $past(exit1, 2)) else $error("ready without full sequence");
    AST_APB_ANSWER: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
        else $error("no APB answer");
    AST_APB_PULSE: assert property (O_PREADY |=> !O_PREADY)
        else $error("pready held");
    COV_BURST_FOUR: cover property (acc && bl4_r);
    COV_BURST_EIGHT: cover property (acc && !bl4_r);
    COV_READY: cover property ($rose(O_READY));
endmodule : dpi_tracker_sva

/* dpi_ctrl_model.sv */
/*
 * Memory controller model that drives the power-up command sequence.
 * Assumes the testbench calls its tasks; MRD is the mode-write gap.
 */
`timescale 1ns/1ns
module dpi_ctrl_model
    import dpi_pkg::*;
#(
    parameter int MRD = 2
)
(
    // Clock.
    input  wire logic              i_clk,
    // Command and address pins towards the device.
    output logic                   o_cke,
    output logic                   o_cs_n,
    output logic                   o_ras_n,
    output logic                   o_cas_n,
    output logic                   o_we_n,
    output logic [BANK_W-1:0]      o_ba,
    output logic [ADDR_W-1:0]      o_a
);
    // ****************************************************************
    // Command tasks
    // ****************************************************************
    localparam logic [3:0] CMD_NOP = 4'h7;
    // Clock enable starts low while power comes up.
    initial begin
        o_cke = 1'b0;
        {o_cs_n, o_ras_n, o_cas_n, o_we_n} = CMD_NOP;
        o_ba = '0;
        o_a = '0;
    end
    // Idle cycles; the unused address lines toggle so nothing stale shows.
    task automatic nop(input int n);
        repeat (n) begin
            @(posedge i_clk);
            {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= CMD_NOP;
            o_ba <= ~o_ba;
            o_a <= ~o_a;
        end
    endtask : nop
    // One command cycle followed by the mode-write recovery gap.
    task automatic issue(input logic [3:0] c, input logic [2:0] b,
                         input logic [15:0] a);
        @(posedge i_clk);
        {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= c;
        o_ba <= b;
        o_a <= a;
        nop(1 + MRD);
    endtask : issue
    // Full power-up sequence; nref below two breaks it on purpose, and
    // nref above two moves registers two and three after the DLL reset.
    task automatic init(input logic [2:0] bl, input logic bt,
                        input logic sedqs, input int nref);
        logic [15:0] mr;
        logic [15:0] emr;
        mr = 16'(bl) | (16'(bt) << A_BT);
        emr = 16'(sedqs) << A_SEDQS;
        @(posedge i_clk);
        o_cke <= 1'b0;
        nop(20000);
        o_cke <= 1'b1;
        nop(40);
        issue(CMD_PRE, BA_MR, 16'h0400);
        if (nref < 3) begin
            issue(CMD_MRS, BA_EMR2, 16'h0000);
            issue(CMD_MRS, BA_EMR3, 16'h0000);
        end
        issue(CMD_MRS, BA_EMR1, emr);
        issue(CMD_MRS, BA_MR, mr | 16'h0100);
        if (nref > 2) begin
            issue(CMD_MRS, BA_EMR2, 16'h0000);
            issue(CMD_MRS, BA_EMR3, 16'h0000);
        end
        issue(CMD_PRE, BA_MR, 16'h0400);
        repeat (nref) issue(CMD_REF, BA_MR, 16'h0000);
        issue(CMD_MRS, BA_MR, mr);
        nop(DLL_LOCK_CLKS);
        issue(CMD_MRS, BA_EMR1, emr | (16'(OCD_DFLT) << A_OCD_LO));
        issue(CMD_MRS, BA_EMR1, emr);
    endtask : init
endmodule : dpi_ctrl_model

/* ddr2_powerup_init_sequence_tb_top.sv */
/*
 * Self-checking bench for the power-up tracker with a controller model.
 * Assumes the model and checker files are compiled before this one.
 */
`timescale 1ns/1ns
module ddr2_powerup_init_sequence_tb_top
    import dpi_pkg::*;
;
    // ****************************************************************
    // Signals, tasks and scoreboard
    // ****************************************************************
    logic              clk, rst, psel, penable, pwrite, cke, cs_n, ras_n;
    logic              cas_n, we_n, o_pready, o_pslverr, o_ready, o_diff;
    logic              o_bvalid;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] a;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, o_prdata, rng;
    logic [COL_W-1:0]  o_bcol;
    logic [64:0]       e;
    logic [64:0]       apb_q[$];
    logic [COL_W-1:0]  col_q[$];
    int                errors, samples_checked;
    dpi_tracker u_dpi_tracker (.I_SYS_CLK(clk), .I_RST(rst), .I_CKE(cke),
        .I_CS_N(cs_n), .I_RAS_N(ras_n), .I_CAS_N(cas_n), .I_WE_N(we_n),
        .I_BA(ba), .I_A(a), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(o_prdata), .O_PREADY(o_pready), .O_PSLVERR(o_pslverr),
        .O_READY(o_ready), .O_DIFF_DQS(o_diff), .O_BURST_VALID(o_bvalid),
        .O_BURST_COL(o_bcol));
    dpi_ctrl_model #(.MRD(2)) u_dpi_ctrl_model (.i_clk(clk), .o_cke(cke),
        .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n),
        .o_ba(ba), .o_a(a));
    // Free-running 100 MHz clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] xorshift();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : xorshift
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // APB transfer; the expectation is noted before the request goes out.
    task automatic apb(input logic wr, input logic [11:0] ad,
        input logic [31:0] wd, input logic err, input logic [31:0] m,
        input logic [31:0] ed);
        apb_q.push_back({err, m, ed});
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, ad, wd};
        @(posedge clk);
        penable <= 1'b1;
        // Hold the access phase until pready is seen at a rising edge.
        do begin
            @(posedge clk);
        end while (o_pready !== 1'b1);
        {psel, penable} <= 2'b00;
    endtask : apb
    // Open a row, then read or write a burst from a random column.
    task automatic burst(input logic [3:0] c, input logic [9:0] m,
                         input logic il);
        logic [9:0] col;
        col = 10'(xorshift());
        u_dpi_ctrl_model.issue(CMD_ACT, 3'(rng >> 20), 16'(rng));
        for (int b = 0; b < 10'(m) + 1; b++) begin
            col_q.push_back(il ? col ^ 10'(b)
                               : (col & ~m) | ((col + 10'(b)) & m));
        end
        u_dpi_ctrl_model.issue(c, 3'(rng >> 20), {6'h00, col});
        repeat (4) @(posedge clk);
    endtask : burst
    // Take each APB answer at the rising edge that completes the access.
    always @(posedge clk) begin
        if (psel && penable && o_pready === 1'b1 && apb_q.size() > 0) begin
            e = apb_q.pop_front();
            check("pslverr", {31'h0, o_pslverr}, {31'h0, e[64]});
            check("prdata", o_prdata & e[63:32], e[31:0]);
        end
    end
    // Compare burst columns at the falling edge, where they are settled.
    always @(negedge clk) begin
        if (o_bvalid === 1'b1) begin
            check("burst_col", 32'(o_bcol),
                  col_q.size() > 0 ? 32'(col_q.pop_front())
                                   : 32'hFFFF_FFFF);
        end
    end
    task automatic stop_test();
        if (errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    // Watchdog sized for three power-up sequences.
    initial begin
        repeat (80000) @(posedge clk);
        errors++;
        stop_test();
    end
    // Main sequence: bad power-up, restart, two good ones with bursts.
    initial begin
        {rst, psel, penable, pwrite} = 4'b1000;
        {paddr, pwdata} = '0;
        {errors, samples_checked, rng} = {64'h0, 32'h0000_000E};
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, REG_CTRL, 32'h0, 1'b0, 32'hFFFF_FFFF, CTRL_RST);
        apb(1'b0, REG_STATUS, 32'h0, 1'b0, 32'h0000_0401, 32'h0);
        apb(1'b0, 12'h0FC, 32'h0, 1'b1, 32'h0, 32'h0);
        u_dpi_ctrl_model.init(BL_FOUR, 1'b0, 1'b0, 1);
        repeat (4) @(posedge clk);
        apb(1'b0, REG_STATUS, 32'h0, 1'b0, 32'h0000_0401, 32'h0000_0400);
        apb(1'b1, REG_CTRL, 32'h1, 1'b0, 32'h0, 32'h0);
        u_dpi_ctrl_model.init(BL_FOUR, 1'b0, 1'b0, 2);
        repeat (4) @(posedge clk);
        apb(1'b0, REG_STATUS, 32'h0, 1'b0, 32'h0000_0403, 32'h0000_0003);
        repeat (3) burst(CMD_RD, 10'h003, 1'b0);
        apb(1'b1, REG_CTRL, 32'h1, 1'b0, 32'h0, 32'h0);
        u_dpi_ctrl_model.init(3'h3, 1'b1, 1'b1, 3);
        repeat (4) @(posedge clk);
        apb(1'b0, REG_STATUS, 32'h0, 1'b0, 32'h0000_0403, 32'h0000_0001);
        repeat (3) burst(CMD_WR, 10'h007, 1'b1);
        apb(1'b0, REG_STATUS, 32'h0, 1'b0, 32'h0000_0C01, 32'h0000_0001);
        repeat (20) @(posedge clk);
        check("left_over", col_q.size() + apb_q.size(), 32'h0);
        stop_test();
    end
endmodule : ddr2_powerup_init_sequence_tb_top
bind dpi_tracker dpi_tracker_sva u_dpi_tracker_sva (.I_SYS_CLK(I_SYS_CLK),
    .I_RST(I_RST), .I_CKE(I_CKE), .I_CS_N(I_CS_N), .I_RAS_N(I_RAS_N),
    .I_CAS_N(I_CAS_N), .I_WE_N(I_WE_N), .I_BA(I_BA), .I_A(I_A),
    .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .O_PREADY(O_PREADY),
    .O_READY(O_READY), .O_DIFF_DQS(O_DIFF_DQS),
    .O_BURST_VALID(O_BURST_VALID), .O_BURST_COL(O_BURST_COL));
